// ### acs_pkg.sv
// package: register map, fields, reset values and enumerations of the conversion sequencer
package acs_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_DATA0   = 8'h00; // data registers 0..7 at 0x00..0x1C
	localparam logic [7:0] OFS_CTRL    = 8'h20; // converter_control_register
	localparam logic [7:0] OFS_CHEN    = 8'h24; // channel enable
	localparam logic [7:0] OFS_CMP     = 8'h28; // compare register
	localparam logic [7:0] OFS_STAT    = 8'h30; // converter_status_register
	localparam logic [7:0] OFS_CLKSEL  = 8'h34; // clock_selection_register
	localparam logic [7:0] OFS_CLOCK_DIVIDER_REGISTER  = 8'h38; // clock_divider_register
	// control register fields
	localparam int CTRL_IE      = 1;  // done_irq_enable
	localparam int CTRL_MD_LO   = 2;  // mode [3:2]
	localparam int CTRL_TRGEN   = 8;  // external trigger enable
	localparam int CTRL_DIFF    = 10; // differential input
	localparam int CTRL_ST      = 11; // conversion_start_bit
	localparam int CTRL_CH7_LO  = 12; // channel 7 source [13:12]
	// compare register fields
	localparam int CMP_EN       = 0;
	localparam int CMP_IE       = 1;
	localparam int CMP_GE       = 2;  // 1: match when result >= value
	localparam int CMP_CH_LO    = 3;  // channel [5:3]
	localparam int CMP_VAL_LO   = 16; // value [27:16]
	// status register fields
	localparam int STAT_DONE    = 0;  // conversion_done_flag
	localparam int STAT_CMPF    = 1;
	localparam int STAT_BUSY    = 2;
	localparam int STAT_CH_LO   = 4;  // current channel [6:4]
	// clock fields
	localparam int CKSEL_LO     = 2;  // source select [3:2]
	localparam int CKDIV_LO     = 16; // prescale [23:16]
	// result register fields
	localparam int RES_OVR      = 16;
	localparam int RES_VLD      = 17;
	// sizes and thresholds
	localparam int NCH          = 8;
	localparam int RES_W        = 12;
	localparam int FIFO_D       = 8;
	localparam logic [3:0] FIFO_FLAG_LVL = 4'h4; // done when count above this
	localparam logic [31:0] RST_VAL  = 32'h0000_0000;
	typedef enum logic [1:0] {
		MD_SINGLE = 2'h0,
		MD_BURST  = 2'h1,
		MD_SCAN1  = 2'h2,
		MD_SCANC  = 2'h3
	} acs_mode_e;
endpackage

// ### acs_clkgen.sv
// converter clock enable: source select and prescaler
`timescale 1ns/1ps
module acs_clkgen
	import acs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] src_sel,
	input  wire logic [7:0] prescale,
	input  wire logic [2:0] src_ena,
	output logic            adc_tick
);
	logic [7:0] cnt_ff;
	logic       tick_ff;
	wire        src_tick = (src_sel == 2'h0) ? src_ena[0] :
	                       (src_sel == 2'h1) ? src_ena[1] :
	                       (src_sel == 2'h2) ? src_ena[2] : 1'b1;
	wire        wrap     = (cnt_ff >= prescale);
	// divide the selected source by prescale+1
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= src_tick && wrap;
			if (src_tick)
				cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
		end
	end
	assign adc_tick = tick_ff;
endmodule // acs_clkgen

// ### acs_fifo.sv
// burst result fifo, eight words of flip-flops
`timescale 1ns/1ps
module acs_fifo
	import acs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              flush,
	input  wire logic              push,
	input  wire logic [RES_W-1:0]  push_data,
	input  wire logic              pop,
	output logic [RES_W-1:0]       head,
	output logic [3:0]             count,
	output logic                   overflow
);
	logic [RES_W-1:0] mem_ff [FIFO_D];
	logic [2:0]       wp_ff;
	logic [2:0]       rp_ff;
	logic [3:0]       cnt_ff;
	wire              full    = (cnt_ff == 4'(FIFO_D));
	wire              do_pop  = pop && (cnt_ff != 4'h0);
	wire              do_push = push && !full;
	// store and pointer update
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wp_ff  <= 3'h0;
			rp_ff  <= 3'h0;
			cnt_ff <= 4'h0;
		end else begin
			if (do_push) begin
				mem_ff[wp_ff] <= push_data;
				wp_ff         <= wp_ff + 3'h1;
			end
			if (do_pop)
				rp_ff <= rp_ff + 3'h1;
			cnt_ff <= cnt_ff + {3'h0, do_push} - {3'h0, do_pop};
		end
	end
	assign head     = (cnt_ff == 4'h0) ? '0 : mem_ff[rp_ff];
	assign count    = cnt_ff;
	assign overflow = push && full;
endmodule // acs_fifo

// ### acs_sequencer.sv
// conversion sequencer top: apb registers, mode sequencing and core handshake
// Operation
// - one 12-bit core, eight channels, four modes
// - start bit set by software or trigger
// - clock source select divided by prescale+1
// - single mode converts once into channel register
// - single done sets flag, interrupt if enabled
// - single: start reads one, cleared at end
// - single mode uses lowest enabled channel only
// - burst fills eight deep fifo via register 0
// - burst flag when fifo holds above four
// - burst repeats while start bit stays one
// - burst converts lowest enabled channel only
// - scan converts enabled channels ascending once
// - scan end sets flag, clears start, idles
// - start cleared mid scan: finish current, stop
// - continuous scan repeats until software stops
// - result registers carry valid and overrun
// - channel 7 selects pin, bandgap or sensor
// - eight single-ended or four differential pairs
// - compare results, optional match interrupt
// - valid cleared on read, overrun on overwrite
// - continuous: flag each pass, restart lowest
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic [31:0]            PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic [2:0]        CLK_SRC_ENA,
	input  wire logic              EXT_TRIGGER_PIN,
	output logic [2:0]             CORE_CHANNEL,
	output logic                   CORE_DIFF,
	output logic [1:0]             CORE_CH7_SRC,
	output logic                   CORE_START,
	input  wire logic              CORE_DONE,
	input  wire logic [RES_W-1:0]  CORE_RESULT,
	output logic                   ADC_IRQ
);
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} acs_state_e;

	acs_state_e       state_ff, nxt_state;
	logic [31:0]      ctrl_ff;
	logic [7:0]       chen_ff;
	logic [31:0]      cmp_ff;
	logic [3:0]       clksel_ff;
	logic [7:0]       clock_divider_register_ff;
	logic             done_ff;
	logic             cmpf_ff;
	logic             st_ff;
	logic [2:0]       ch_ff;
	logic             irq_pend_ff;
	logic             core_start_ff;
	logic [RES_W-1:0] res_ff [NCH];
	logic [NCH-1:0]   vld_ff;
	logic [NCH-1:0]   ovr_ff;
	logic [2:0]       trg_sync_ff;
	logic             trg_prev_ff;
	logic             tick_pend_ff;
	logic [31:0]      rdata_ff;

	// apb decode
	wire        acc      = PSEL && PENABLE;
	wire        wr       = acc && PWRITE;
	wire        rd       = acc && !PWRITE;
	wire        is_data  = (PADDR[7:5] == 3'h0) && (PADDR[1:0] == 2'h0);
	wire [2:0]  rd_idx   = PADDR[4:2];
	wire        hit_ctrl = (PADDR == OFS_CTRL);
	wire        hit_chen = (PADDR == OFS_CHEN);
	wire        hit_cmp  = (PADDR == OFS_CMP);
	wire        hit_stat = (PADDR == OFS_STAT);
	wire        hit_csel = (PADDR == OFS_CLKSEL);
	wire        hit_cdiv = (PADDR == OFS_CLOCK_DIVIDER_REGISTER);
	wire        mapped   = is_data || hit_ctrl || hit_chen || hit_cmp || hit_stat
	                       || hit_csel || hit_cdiv;
	wire [1:0]  mode     = ctrl_ff[CTRL_MD_LO +: 2];
	wire        burst    = (mode == MD_BURST);

	// lowest enabled channel and next enabled channel above current
	logic [2:0] low_ch;
	logic [2:0] next_ch;
	logic       has_next;
	always_comb begin
		low_ch   = 3'h0;
		next_ch  = 3'h0;
		has_next = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (chen_ff[i])
				low_ch = 3'(i);
			if (chen_ff[i] && (3'(i) > ch_ff)) begin
				next_ch  = 3'(i);
				has_next = 1'b1;
			end
		end
	end

	// converter clock enable
	logic adc_tick;
	acs_clkgen u_clkgen (
		.clk      (CLK),
		.rst_n    (RST_N),
		.src_sel  (clksel_ff[CKSEL_LO +: 2]),
		.prescale (clock_divider_register_ff),
		.src_ena  (CLK_SRC_ENA),
		.adc_tick (adc_tick)
	);

	// burst fifo
	logic [RES_W-1:0] fifo_head;
	logic [3:0]       fifo_cnt;
	logic             fifo_ovf;
	wire              cap      = (state_ff == ST_WAIT) && CORE_DONE;
	wire              fifo_pop = rd && (PADDR == OFS_DATA0) && burst;
	acs_fifo u_fifo (
		.clk       (CLK),
		.rst_n     (RST_N),
		.flush     (wr && hit_ctrl && !PWDATA[CTRL_ST]),
		.push      (cap && burst),
		.push_data (CORE_RESULT),
		.pop       (fifo_pop),
		.head      (fifo_head),
		.count     (fifo_cnt),
		.overflow  (fifo_ovf)
	);

	// trigger pin: three stage synchroniser, rising edge when stages two and three agree
	wire trg_lvl  = trg_sync_ff[1] && trg_sync_ff[2];
	wire trg_rise = trg_lvl && !trg_prev_ff && ctrl_ff[CTRL_TRGEN];
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			trg_sync_ff <= 3'h0;
			trg_prev_ff <= 1'b0;
		end else begin
			trg_sync_ff <= {trg_sync_ff[1:0], EXT_TRIGGER_PIN};
			if (trg_sync_ff[1] == trg_sync_ff[2])
				trg_prev_ff <= trg_sync_ff[2];
		end
	end

	// sequencing decisions at capture time
	wire last_ch   = !has_next || (mode == MD_SINGLE) || burst;
	wire pass_end  = cap && last_ch && !burst;
	wire one_shot  = (mode == MD_SINGLE) || (mode == MD_SCAN1);
	wire hw_clear  = pass_end && one_shot;
	wire sw_set    = wr && hit_ctrl && PWDATA[CTRL_ST];
	wire sw_clr    = wr && hit_ctrl && !PWDATA[CTRL_ST];
	wire st_set    = sw_set || trg_rise;
	wire cmp_hit   = cap && cmp_ff[CMP_EN] && (ch_ff == cmp_ff[CMP_CH_LO +: 3]) &&
	                 ((CORE_RESULT >= cmp_ff[CMP_VAL_LO +: RES_W]) == cmp_ff[CMP_GE]);
	wire burst_flg = burst && (fifo_cnt > FIFO_FLAG_LVL);
	wire done_set  = pass_end || burst_flg;
	wire clr_done  = wr && hit_stat && PWDATA[STAT_DONE];
	wire clr_cmpf  = wr && hit_stat && PWDATA[STAT_CMPF];

	// state machine: start on a converter tick, wait for core done
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE:  if (st_ff && adc_tick) nxt_state = ST_START;
			ST_START: nxt_state = ST_WAIT;
			ST_WAIT: begin
				if (CORE_DONE)
					nxt_state = ST_IDLE; // stop after current when start cleared
			end
		endcase
	end

	// state, channel pointer and core start pulse
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_ff      <= ST_IDLE;
			ch_ff         <= 3'h0;
			core_start_ff <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			core_start_ff <= (nxt_state == ST_START);
			if (state_ff == ST_IDLE && !st_ff)
				ch_ff <= low_ch;
			else if (cap)
				ch_ff <= last_ch ? low_ch : next_ch;
		end
	end

	// start bit: set wins over hardware clear
	always_ff @(posedge CLK) begin
		if (!RST_N)
			st_ff <= 1'b0;
		else if (st_set)
			st_ff <= 1'b1;
		else if (sw_clr || hw_clear)
			st_ff <= 1'b0;
	end

	// configuration registers written by software
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_ff   <= RST_VAL;
			chen_ff   <= RST_VAL[7:0];
			cmp_ff    <= RST_VAL;
			clksel_ff <= RST_VAL[3:0];
			clock_divider_register_ff <= RST_VAL[7:0];
		end else if (wr) begin
			if (hit_ctrl)
				ctrl_ff <= PWDATA & 32'h0000_350E; // start bit lives in st_ff
			if (hit_chen)
				chen_ff <= PWDATA[7:0];
			if (hit_cmp)
				cmp_ff <= PWDATA & 32'h0FFF_003F;
			if (hit_csel)
				clksel_ff <= PWDATA[3:0];
			if (hit_cdiv)
				clock_divider_register_ff <= PWDATA[CKDIV_LO +: 8];
		end
	end

	// sticky flags, event set wins over software clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			done_ff     <= 1'b0;
			cmpf_ff     <= 1'b0;
			irq_pend_ff <= 1'b0;
		end else begin
			if (done_set)
				done_ff <= 1'b1;
			else if (clr_done)
				done_ff <= 1'b0;
			if (cmp_hit)
				cmpf_ff <= 1'b1;
			else if (clr_cmpf)
				cmpf_ff <= 1'b0;
			// burst interrupt waits for the end of the running conversion
			irq_pend_ff <= done_ff && (irq_pend_ff || !burst || state_ff != ST_WAIT || cap);
		end
	end

	// per-channel results with valid and overrun
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_res
			wire load   = cap && !burst && (ch_ff == 3'(g));
			wire rd_hit = rd && is_data && (rd_idx == 3'(g));
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					res_ff[g] <= '0;
					vld_ff[g] <= 1'b0;
					ovr_ff[g] <= 1'b0;
				end else if (load) begin
					res_ff[g] <= CORE_RESULT;
					vld_ff[g] <= 1'b1;
					ovr_ff[g] <= vld_ff[g] && !rd_hit;
				end else if (rd_hit) begin
					vld_ff[g] <= 1'b0;
					ovr_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// read data mux; register 0 shows the fifo head in burst mode
	wire [RES_W-1:0] sel_res = (burst && rd_idx == 3'h0) ? fifo_head : res_ff[rd_idx];
	wire             sel_vld = (burst && rd_idx == 3'h0) ? (fifo_cnt != 4'h0) : vld_ff[rd_idx];
	wire             sel_ovr = (burst && rd_idx == 3'h0) ? fifo_ovf : ovr_ff[rd_idx];
	wire [31:0]      ctrl_rd = ctrl_ff | (32'(st_ff) << CTRL_ST);
	wire [31:0]      stat_rd = (32'(done_ff) << STAT_DONE) | (32'(cmpf_ff) << STAT_CMPF) |
	                           (32'(state_ff != ST_IDLE) << STAT_BUSY) |
	                           (32'(ch_ff) << STAT_CH_LO);
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (is_data)
			rmux = {14'h0, sel_vld, sel_ovr, 4'h0, sel_res};
		else if (hit_ctrl)
			rmux = ctrl_rd;
		else if (hit_chen)
			rmux = {24'h0, chen_ff};
		else if (hit_cmp)
			rmux = cmp_ff;
		else if (hit_stat)
			rmux = stat_rd;
		else if (hit_csel)
			rmux = {28'h0, clksel_ff};
		else if (hit_cdiv)
			rmux = {8'h0, clock_divider_register_ff, 16'h0};
	end

	// read data register, captured in the setup cycle
	always_ff @(posedge CLK) begin
		if (!RST_N)
			rdata_ff <= 32'h0000_0000;
		else if (PSEL && !PENABLE)
			rdata_ff <= rmux;
	end

	assign PRDATA       = rdata_ff;
	assign PREADY       = 1'b1;
	assign PSLVERR      = acc && !mapped;
	assign CORE_CHANNEL = ch_ff;
	assign CORE_START   = core_start_ff;
	assign CORE_DIFF    = ctrl_ff[CTRL_DIFF];
	assign CORE_CH7_SRC = ctrl_ff[CTRL_CH7_LO +: 2];
	assign ADC_IRQ      = (irq_pend_ff && ctrl_ff[CTRL_IE]) ||
	                      (cmpf_ff && cmp_ff[CMP_IE]);
endmodule // acs_sequencer

// ### acs_core_model.sv
// behavioural sar core facing the sequencer
`timescale 1ns/1ps
module acs_core_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        slow,
	input  wire logic        start,
	input  wire logic [2:0]  channel,
	output logic             done,
	output logic [11:0]      result
);
	logic [3:0]  cnt_ff;
	logic        busy_ff;
	logic [2:0]  ch_ff;
	logic [7:0]  seq_ff;
	logic [11:0] res_ff;
	// take a start pulse, convert, flag done for one cycle
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (!rst_n) begin
			busy_ff <= 1'b0;
			seq_ff <= 8'h00;
			res_ff <= 12'h000;
		end else if (start && !busy_ff) begin
			busy_ff <= 1'b1;
			ch_ff <= channel;
			cnt_ff <= slow ? 4'h9 : 4'h2;
		end else if (busy_ff && cnt_ff == 4'h0) begin
			busy_ff <= 1'b0;
			done <= 1'b1;
			res_ff <= {ch_ff, 1'b0, seq_ff};
			seq_ff <= seq_ff + 8'h01;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end
	// result only meaningful while done is up
	assign result = done ? res_ff : ~res_ff;
endmodule // acs_core_model

// ### acs_seq_properties.sv
// port assertions of the conversion sequencer
`timescale 1ns/1ps
module acs_seq_properties (
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PSLVERR,
	input wire logic [2:0]  CORE_CHANNEL,
	input wire logic        CORE_DIFF,
	input wire logic [1:0]  CORE_CH7_SRC,
	input wire logic        CORE_START,
	input wire logic        ADC_IRQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// access phase and address decode
	wire acc  = PSEL & PENABLE;
	wire bad  = (PADDR == 8'h2C) || (PADDR >= 8'h3C);
	wire dreg = (PADDR < 8'h20) && (PADDR[1:0] == 2'h0);
	wire stop = acc && PWRITE && PADDR == 8'h20 && !PWDATA[11] && !PWDATA[8];
	AST_START_SPACED: assert property (CORE_START |=> !CORE_START [*3])
		else $error("start pulse too long or too close");
	AST_CH_HELD: assert property (CORE_START |=> $stable(CORE_CHANNEL) [*2])
		else $error("channel moved during conversion");
	AST_CFG_BY_WRITE: assert property (!$stable({CORE_DIFF, CORE_CH7_SRC})
		|-> $past(acc && PWRITE && PADDR == 8'h20))
		else $error("input config changed without write");
	AST_IRQ_STICKY: assert property ($fell(ADC_IRQ) |-> $past(acc && PWRITE) || $past(acc && PWRITE, 2))
		else $error("interrupt dropped on its own");
	AST_UNMAPPED: assert property (acc && bad |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
	AST_DATA_OK: assert property (acc && dreg |-> !PSLVERR)
		else $error("data register refused");
	AST_DATA_FIELDS: assert property (acc && !PWRITE && dreg
		|-> PRDATA[31:18] == 14'h0 && PRDATA[15:12] == 4'h0)
		else $error("data register reserved bits set");
	AST_STOP: assert property (stop |-> ##3 !CORE_START [*8])
		else $error("conversion started after stop");
	cover property (CORE_START);
	cover property ($rose(ADC_IRQ));
	cover property (acc && bad);
endmodule // acs_seq_properties

// ### tb.sv
// testbench: register-level tests of the sequencer with a core model
`timescale 1ns/1ps
module tb
	import acs_pkg::*;
;
	logic             CLK = 1'b0;
	logic             RST_N = 1'b0;
	logic             PSEL = 1'b0;
	logic             PENABLE = 1'b0;
	logic             PWRITE = 1'b0;
	logic [7:0]       PADDR = 8'h00;
	logic [31:0]      PWDATA = 32'h0;
	logic [31:0]      PRDATA;
	logic             PREADY, PSLVERR, CORE_START, CORE_DONE, CORE_DIFF, ADC_IRQ;
	logic [2:0]       CORE_CHANNEL;
	logic [1:0]       CORE_CH7_SRC;
	logic [RES_W-1:0] CORE_RESULT;
	logic             EXT_TRIGGER_PIN = 1'b0;
	logic             slow = 1'b0;
	logic [1:0]       srcn = 2'h0;
	logic [31:0]      rdv;
	logic [7:0]       prev;
	logic [7:0]       en = 8'h8D;
	int               n_mismatch = 0;
	int               total_checks = 0;
	// clock and converter source enables
	always #5 CLK = ~CLK;
	always @(posedge CLK) srcn <= srcn + 2'h1;
	acs_sequencer acs_sequencer_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CLK_SRC_ENA({srcn == 2'h0, srcn[0], 1'b1}), .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN),
		.CORE_CHANNEL(CORE_CHANNEL), .CORE_DIFF(CORE_DIFF), .CORE_CH7_SRC(CORE_CH7_SRC),
		.CORE_START(CORE_START), .CORE_DONE(CORE_DONE), .CORE_RESULT(CORE_RESULT),
		.ADC_IRQ(ADC_IRQ));
	acs_core_model acs_core_model_i (.clk(CLK), .rst_n(RST_N), .slow(slow),
		.start(CORE_START), .channel(CORE_CHANNEL), .done(CORE_DONE), .result(CORE_RESULT));
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rdv = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	// interrupt line once the edge has settled
	task automatic ichk(input logic e);
		@(posedge CLK);
		@(negedge CLK);
		chk({31'h0, ADC_IRQ}, {31'h0, e});
	endtask
	// poll status until masked bits match
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, OFS_STAT, 32'h0);
			if ((rdv & m) === v) break;
		end
		chk(rdv & m, v);
	endtask
	// data register: valid, overrun and channel tag of the sample
	task automatic dchk(input logic [2:0] c, input logic [1:0] vo, input logic [2:0] ec);
		apb(1'b0, {3'h0, c, 2'h0}, 32'h0);
		chk({rdv[17:16], rdv[11:9]}, {vo, ec});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge CLK);
		n_mismatch++;
		tally_and_finish();
	end
	// test sequence
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		rchk(OFS_CTRL, RST_VAL);
		rchk(8'h2C, 32'h0);
		wr(8'h2C, 32'hFFFF_FFFF);
		rchk(OFS_DATA0, RST_VAL);
		$display("test reset done");
		// single mode, two channels enabled, interrupt on
		wr(OFS_CHEN, 32'h24);
		wr(OFS_CTRL, 32'h802);
		rchk(OFS_CTRL, 32'h802);
		wait_st(32'h1, 32'h1);
		ichk(1'b1);
		rchk(OFS_CTRL, 32'h002);
		dchk(3'h2, 2'h2, 3'h2);
		dchk(3'h5, 2'h0, 3'h0);
		dchk(3'h2, 2'h0, 3'h2);
		wr(OFS_STAT, 32'h1);
		ichk(1'b0);
		// two conversions with no read between
		wr(OFS_CTRL, 32'h800);
		wait_st(32'h1, 32'h1);
		wr(OFS_STAT, 32'h1);
		wr(OFS_CTRL, 32'h800);
		wait_st(32'h1, 32'h1);
		dchk(3'h2, 2'h3, 3'h2);
		wr(OFS_STAT, 32'h1);
		$display("test single done");
		// one scan pass over channels 0 2 3 7, slow core
		slow <= 1'b1;
		wr(OFS_CHEN, {24'h0, en});
		wr(OFS_CTRL, 32'h808);
		wait_st(32'h5, 32'h1);
		rchk(OFS_CTRL, 32'h008);
		for (int i = 0; i < 8; i++) begin
			dchk(3'(i), en[i] ? 2'h2 : 2'h0, en[i] ? 3'(i) : 3'h0);
		end
		wr(OFS_STAT, 32'h1);
		$display("test scan done");
		// continuous scan with channel 7 on the reference
		wr(OFS_CTRL, 32'h180C);
		wait_st(32'h5, 32'h5);
		wr(OFS_STAT, 32'h1);
		wait_st(32'h5, 32'h5);
		wr(OFS_CTRL, 32'h100C);
		wait_st(32'h4, 32'h0);
		dchk(3'h7, 2'h3, 3'h7);
		wr(OFS_STAT, 32'h1);
		wr(OFS_CTRL, 32'h400);
		wr(OFS_CTRL, 32'h0);
		$display("test continuous done");
		// burst on the lower of two channels, fifo order
		slow <= 1'b0;
		wr(OFS_CHEN, 32'h30);
		wr(OFS_CTRL, 32'h804);
		wait_st(32'h1, 32'h1);
		apb(1'b0, OFS_DATA0, 32'h0);
		prev = rdv[7:0];
		chk({rdv[17], rdv[11:9]}, {1'b1, 3'h4});
		repeat (4) begin
			apb(1'b0, OFS_DATA0, 32'h0);
			chk({rdv[17], rdv[11:0]}, {4'hC, 1'b0, prev + 8'h01});
			prev = rdv[7:0];
		end
		wr(OFS_CTRL, 32'h4);
		wait_st(32'h4, 32'h0);
		wr(OFS_STAT, 32'h1);
		$display("test burst done");
		// divided clock, pin trigger, compare interrupt only
		wr(OFS_CLKSEL, 32'hC);
		wr(OFS_CLOCK_DIVIDER_REGISTER, 32'h0006_0000);
		rchk(OFS_CLKSEL, 32'hC);
		rchk(OFS_CLOCK_DIVIDER_REGISTER, 32'h0006_0000);
		wr(OFS_CHEN, 32'h04);
		wr(OFS_CMP, 32'h17);
		wr(OFS_CTRL, 32'h100);
		EXT_TRIGGER_PIN <= 1'b1;
		wait_st(32'h3, 32'h3);
		ichk(1'b1);
		wr(OFS_STAT, 32'h3);
		ichk(1'b0);
		$display("test trigger done");
		tally_and_finish();
	end
endmodule // tb
bind acs_sequencer acs_seq_properties acs_seq_properties_i (.CLK(CLK), .RST_N(RST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .CORE_CHANNEL(CORE_CHANNEL), .CORE_DIFF(CORE_DIFF),
	.CORE_CH7_SRC(CORE_CH7_SRC), .CORE_START(CORE_START), .ADC_IRQ(ADC_IRQ));
